// ===== hw/bmf_top.sv
// Bus-matching buffer: mode capture, offsets, byte packing, flags and retransmit
`timescale 1ns/10ps
`default_nettype none
module bmf_top
    import bmf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_tick,
    input wire logic rd_tick,
    input wire logic write_enable_n,
    input wire logic read_enable_n,
    input wire logic [WORD_W-1:0] data_in_bus,
    output logic [WORD_W-1:0] data_out_bus,
    input wire logic master_clear_n,
    input wire logic partial_clear_n,
    input wire logic fall_through_or_serial_in,
    input wire logic serial_load_enable_n,
    input wire logic offset_load_select_n,
    input wire logic default_offset_sel_lo,
    input wire logic default_offset_sel_hi,
    input wire logic almost_flag_timing_select,
    input wire logic retransmit_request_n,
    input wire logic retransmit_latency_select,
    input wire logic byte_order_select,
    input wire logic parity_placement_select,
    input wire logic input_width_select,
    input wire logic output_width_select,
    output logic empty_or_output_valid_n,
    output logic full_or_input_space_n,
    output logic half_full_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    output logic power_down
);
    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic ft;
        logic sync_af;
        logic rt_zero;
        logic le;
        logic ip;
        logic iw9;
        logic ow9;
        logic [OFS_W-1:0] ae_off;
        logic [OFS_W-1:0] af_off;
        logic pld_sel;
        logic prd_sel;
        logic wr_half;
        logic [BYTE_W-1:0] wr_byte;
        logic rd_half;
        logic [BYTE_W-1:0] rd_hold;
        logic [WORD_W-1:0] q;
        logic q_valid;
        logic load_pend;
        logic [1:0] ft_wait;
        logic rd_tick_d;
        logic wr_tick_d;
        logic ef_n;
        logic ff_n;
        logic hf_n;
        logic pae_n;
        logic paf_n;
    } bmf_state_s;

    bmf_state_s st_r;
    bmf_state_s st_nxt;

    logic clr_n;
    logic [2:0] def_idx;
    logic [OFS_W-1:0] par_ofs;
    logic fifo_push;
    logic [WORD_W-1:0] fifo_wdata;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [WORD_W-1:0] fifo_rdata;
    logic fifo_rewind;
    logic fifo_rw_pop;
    logic [LVL_W-1:0] fifo_level;
    logic [LVL_W-1:0] fifo_stored;
    logic [LVL_W-1:0] lvl_eff;
    logic ae_cond;
    logic af_cond;

    assign clr_n = master_clear_n && partial_clear_n;
    assign def_idx = {offset_load_select_n, default_offset_sel_hi, default_offset_sel_lo};
    // Interspersed parity drops bit 8 and takes the offset around it
    assign par_ofs = (st_r.ip && !st_r.iw9)
        ? {data_in_bus[PAR_BIT+2:PAR_BIT+1], data_in_bus[PAR_BIT-1:0]}
        : data_in_bus[OFS_W-1:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Storage

    bmf_fifo #(.W(WORD_W), .D(DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .clr(!clr_n),
        .rewind(fifo_rewind),
        .rewind_pop(fifo_rw_pop),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_wdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_rdata),
        .level(fifo_level),
        .stored(fifo_stored)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;
        fifo_push = 1'b0;
        fifo_wdata = '0;
        fifo_pop = 1'b0;
        fifo_rewind = 1'b0;
        fifo_rw_pop = 1'b0;
        st_nxt.rd_tick_d = rd_tick;
        st_nxt.wr_tick_d = wr_tick;

        if (!master_clear_n) begin
            st_nxt.ft = fall_through_or_serial_in;
            st_nxt.sync_af = almost_flag_timing_select;
            st_nxt.rt_zero = !retransmit_latency_select;
            st_nxt.le = byte_order_select;
            st_nxt.ip = parity_placement_select;
            st_nxt.iw9 = input_width_select;
            st_nxt.ow9 = output_width_select;
            st_nxt.ae_off = DEF_OFS[def_idx];
            st_nxt.af_off = DEF_OFS[def_idx];
            st_nxt.pld_sel = 1'b0;
            st_nxt.prd_sel = 1'b0;
        end

        if (!clr_n) begin
            // Partial clear drops data in flight but keeps modes and offsets
            st_nxt.wr_half = 1'b0;
            st_nxt.rd_half = 1'b0;
            st_nxt.q_valid = 1'b0;
            st_nxt.load_pend = 1'b0;
            st_nxt.ft_wait = 2'h0;
            st_nxt.q = '0;
        end else begin
            // Write side
            if (wr_tick) begin
                if (!offset_load_select_n && !write_enable_n) begin
                    if (st_r.pld_sel) begin
                        st_nxt.af_off = par_ofs;
                    end else begin
                        st_nxt.ae_off = par_ofs;
                    end
                    st_nxt.pld_sel = !st_r.pld_sel;
                end else if (!offset_load_select_n && !serial_load_enable_n) begin
                    // Empty offset leaves first, new bit enters the full offset
                    {st_nxt.ae_off, st_nxt.af_off} =
                        {st_r.ae_off[OFS_W-2:0], st_r.af_off, fall_through_or_serial_in};
                end else if (!write_enable_n && fifo_in_ready) begin
                    if (st_r.iw9 && !st_r.ow9 && !st_r.wr_half) begin
                        st_nxt.wr_byte = data_in_bus[BYTE_W-1:0];
                        st_nxt.wr_half = 1'b1;
                    end else begin
                        fifo_push = 1'b1;
                        st_nxt.wr_half = 1'b0;
                        if (st_r.iw9 && !st_r.ow9) begin
                            fifo_wdata = st_r.le ? {data_in_bus[BYTE_W-1:0], st_r.wr_byte}
                                                 : {st_r.wr_byte, data_in_bus[BYTE_W-1:0]};
                        end else if (st_r.iw9) begin
                            fifo_wdata = {{BYTE_W{1'b0}}, data_in_bus[BYTE_W-1:0]};
                        end else begin
                            fifo_wdata = data_in_bus;
                        end
                    end
                end
            end

            // Word fetched from storage lands one cycle after the pop
            if (st_r.load_pend) begin
                st_nxt.load_pend = 1'b0;
                st_nxt.q_valid = 1'b1;
                if (!st_r.iw9 && st_r.ow9) begin
                    st_nxt.rd_half = 1'b1;
                    if (st_r.le) begin
                        st_nxt.q = {{BYTE_W{1'b0}}, fifo_rdata[BYTE_W-1:0]};
                        st_nxt.rd_hold = fifo_rdata[WORD_W-1:BYTE_W];
                    end else begin
                        st_nxt.q = {{BYTE_W{1'b0}}, fifo_rdata[WORD_W-1:BYTE_W]};
                        st_nxt.rd_hold = fifo_rdata[BYTE_W-1:0];
                    end
                end else begin
                    st_nxt.q = fifo_rdata;
                end
            end

            // Read side
            if (rd_tick) begin
                if (!offset_load_select_n && !read_enable_n) begin
                    st_nxt.q = {{(WORD_W-OFS_W){1'b0}}, st_r.prd_sel ? st_r.af_off : st_r.ae_off};
                    st_nxt.prd_sel = !st_r.prd_sel;
                end else if (!retransmit_request_n) begin
                    fifo_rewind = 1'b1;
                    st_nxt.rd_half = 1'b0;
                    st_nxt.q_valid = 1'b0;
                    st_nxt.ft_wait = 2'h0;
                    if (st_r.rt_zero && fifo_stored != '0) begin
                        fifo_rw_pop = 1'b1;
                        st_nxt.load_pend = 1'b1;
                    end
                end else if (!read_enable_n && (!st_r.ft || st_r.q_valid)) begin
                    if (st_r.rd_half) begin
                        st_nxt.q = {{BYTE_W{1'b0}}, st_r.rd_hold};
                        st_nxt.rd_half = 1'b0;
                    end else if (fifo_out_valid && !st_r.load_pend) begin
                        fifo_pop = 1'b1;
                        st_nxt.load_pend = 1'b1;
                        st_nxt.q_valid = 1'b0;
                    end else begin
                        st_nxt.q_valid = 1'b0;
                    end
                end else if (st_r.ft && !st_r.q_valid && !st_r.load_pend && fifo_out_valid) begin
                    // First word falls through unasked after a short read-clock delay
                    if (st_r.ft_wait == FT_TICKS - 2'h1) begin
                        fifo_pop = 1'b1;
                        st_nxt.load_pend = 1'b1;
                        st_nxt.ft_wait = 2'h0;
                    end else begin
                        st_nxt.ft_wait = st_r.ft_wait + 2'h1;
                    end
                end
            end
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Flags, seen as empty while any clear is held

        lvl_eff = clr_n ? fifo_level : '0;
        ae_cond = OFS_W'(lvl_eff) <= st_nxt.ae_off;
        af_cond = ({1'b0, OFS_W'(lvl_eff)} + {1'b0, st_nxt.af_off}) >= DEPTH_X;

        if (!clr_n) begin
            st_nxt.pae_n = !ae_cond;
            st_nxt.paf_n = !af_cond;
        end else if (st_r.sync_af) begin
            if (st_r.rd_tick_d) begin
                st_nxt.pae_n = !ae_cond;
            end
            if (st_r.wr_tick_d) begin
                st_nxt.paf_n = !af_cond;
            end
        end else begin
            if (st_r.rd_tick_d && ae_cond) begin
                st_nxt.pae_n = 1'b0;
            end else if (st_r.wr_tick_d && !ae_cond) begin
                st_nxt.pae_n = 1'b1;
            end
            if (st_r.wr_tick_d && af_cond) begin
                st_nxt.paf_n = 1'b0;
            end else if (st_r.rd_tick_d && !af_cond) begin
                st_nxt.paf_n = 1'b1;
            end
        end

        st_nxt.hf_n = !(lvl_eff > HALF_LVL);
        if (st_nxt.ft) begin
            st_nxt.ef_n = !st_nxt.q_valid;
            st_nxt.ff_n = clr_n ? !fifo_in_ready : 1'b0;
        end else begin
            st_nxt.ef_n = (lvl_eff != '0) || st_nxt.rd_half;
            st_nxt.ff_n = clr_n ? fifo_in_ready : 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.ff_n <= 1'b1;
            st_r.hf_n <= 1'b1;
            st_r.paf_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign data_out_bus = st_r.q;
    assign empty_or_output_valid_n = st_r.ef_n;
    assign full_or_input_space_n = st_r.ff_n;
    assign half_full_flag_n = st_r.hf_n;
    assign almost_empty_flag_n = st_r.pae_n;
    assign almost_full_flag_n = st_r.paf_n;
    // Combinational so that any control activity ends power-down at once
    assign power_down = clr_n && !st_r.load_pend
        && !(wr_tick && !(write_enable_n && serial_load_enable_n))
        && !(rd_tick && !(read_enable_n && retransmit_request_n));

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_ft_fetch;
        clr_n && st_r.ft && !st_r.q_valid && !st_r.load_pend && fifo_out_valid && rd_tick
            && read_enable_n && retransmit_request_n && st_r.ft_wait == FT_TICKS - 2'h1;
    endsequence

    sequence s_ft_shown;
        ##1 st_r.load_pend ##1 (st_r.q_valid && !empty_or_output_valid_n == st_r.q_valid);
    endsequence

    a_mode_latch: assert property (!master_clear_n |=> st_r.ft == $past(fall_through_or_serial_in))
        else $error("timing mode not latched at master clear");
    a_default_pick: assert property (!master_clear_n
        |=> st_r.ae_off == DEF_OFS[$past(def_idx)] && st_r.af_off == st_r.ae_off)
        else $error("default offset pair wrong");
    a_serial_shift: assert property (clr_n && wr_tick && !offset_load_select_n
        && !serial_load_enable_n && write_enable_n |=> st_r.af_off[0] == $past(fall_through_or_serial_in))
        else $error("serial offset bit not shifted in");
    a_parallel_load: assert property (clr_n && wr_tick && !offset_load_select_n
        && !write_enable_n && !st_r.pld_sel |=> st_r.ae_off == $past(par_ofs) && st_r.pld_sel)
        else $error("parallel offset not loaded");
    a_offset_read: assert property (clr_n && rd_tick && !offset_load_select_n
        && !read_enable_n && !st_r.prd_sel |=> data_out_bus == {8'h00, $past(st_r.ae_off)})
        else $error("offset readback wrong");
    a_master_ptrs: assert property (!master_clear_n |=> fifo_level == '0 && !st_r.q_valid)
        else $error("master clear left data");
    a_partial_keep: assert property (master_clear_n && !partial_clear_n
        |=> fifo_level == '0 && $stable(st_r.ae_off) && $stable(st_r.ft) && $stable(st_r.af_off))
        else $error("partial clear lost settings");
    a_sync_pae: assert property (clr_n && st_r.sync_af && !st_r.rd_tick_d
        |=> almost_empty_flag_n == $past(almost_empty_flag_n))
        else $error("almost-empty moved off a read tick");
    a_ft_fetch: assert property (s_ft_fetch |-> s_ft_shown)
        else $error("first word did not fall through");
    a_rt_zero: assert property (clr_n && rd_tick && !retransmit_request_n
        && (offset_load_select_n || read_enable_n) && st_r.rt_zero && fifo_stored != '0
        |=> st_r.load_pend ##1 st_r.q_valid)
        else $error("zero-latency retransmit word not loaded");
    a_order_big: assert property (clr_n && st_r.load_pend && !rd_tick
        && !st_r.iw9 && st_r.ow9 && !st_r.le |=> data_out_bus[BYTE_W-1:0] == $past(fifo_rdata[WORD_W-1:BYTE_W]))
        else $error("big-endian high byte not first");
endmodule : bmf_top
`default_nettype wire

// ===== hw/bmf_pkg.sv
// Constants shared by the bus-matching first-in-first-out buffer
//
// Contract
// - Fall-through shows the first word unasked; later words need a read request.
// - Master clear latches fall-through select; it holds until the next master clear.
// - Standard mode drives empty/full; fall-through drives valid/space; others always.
// - Master clear picks one of eight default offset pairs from three inputs.
// - Serial load enable with offset select shifts one serial bit per write tick.
// - Write enable with offset select loads an offset from the data input.
// - Read enable with offset select presents offset contents on the data output.
// - Master clear returns read and write pointers to the first location.
// - Partial clear resets pointers, keeps mode and offsets, recomputes every flag.
// - Asynchronous timing: almost flags fall on one side's tick, rise on other's.
// - Synchronous timing: almost-empty moves on read ticks, almost-full on write ticks.
// - Almost-flag timing select is captured during master clear.
// - Retransmit request low on a read tick rewinds the read pointer.
// - Retransmit latency select low means zero latency, high means normal latency.
// - Zero-latency retransmit loads the first word in response to the request edge.
// - Wide-to-narrow reads: big-endian gives high byte first, little-endian low first.
// - Interspersed parity skips bit 8 in parallel offsets; otherwise bits 16,17 ignored.
// - Parity placement latched at master clear; affects only wide parallel offset loads.
// - Width selects set 18 or 9 bit write and read ports independently.
// - Idle block signals power-down and leaves it as soon as a control acts.
// - Byte order select low means big-endian, high means little-endian.
// - Port widths are fixed by width selects captured during master clear.
// - Fall-through: a word in an empty buffer needs read-clock transitions before showing.
package bmf_pkg;
    localparam int WORD_W = 18;
    localparam int BYTE_W = 9;
    localparam int DEPTH = 16;
    localparam int LVL_W = 5;
    localparam int OFS_W = 10;
    localparam int PAR_BIT = 8;
    localparam logic [LVL_W-1:0] HALF_LVL = 5'h08;
    localparam logic [OFS_W:0] DEPTH_X = 11'h010;
    localparam logic [1:0] FT_TICKS = 2'h2;
    localparam logic [OFS_W-1:0] DEF_OFS [0:7] = '{
        10'h001, 10'h002, 10'h003, 10'h004, 10'h005, 10'h006, 10'h007, 10'h008
    };
endpackage : bmf_pkg

// ===== hw/bmf_mem.sv
// Word storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module bmf_mem #(
    parameter int W = 18,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [$clog2(D)-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic re,
    input wire logic [$clog2(D)-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [0:D-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read during write of the same slot returns the old word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule : bmf_mem
`default_nettype wire

// ===== hw/bmf_fifo.sv
// Parameterised buffer with valid/ready on both sides and a rewind port
`timescale 1ns/10ps
`default_nettype none
module bmf_fifo #(
    parameter int W = 18,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic rewind,
    input wire logic rewind_pop,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level,
    output logic [$clog2(D):0] stored
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } bmf_fifo_s;

    bmf_fifo_s st_r;
    bmf_fifo_s st_nxt;
    logic push;
    logic pop;
    logic [AW-1:0] raddr;

    assign level = st_r.wp - st_r.rp;
    assign stored = st_r.wp;
    assign in_ready = level != (AW+1)'(D);
    assign out_valid = level != '0;
    assign push = in_valid && in_ready && !clr;
    assign pop = out_valid && out_ready && !clr && !rewind;
    assign raddr = rewind ? '0 : st_r.rp[AW-1:0];

    always_comb begin
        st_nxt = st_r;
        if (clr) begin
            st_nxt = '0;
        end else begin
            if (push) begin
                st_nxt.wp = st_r.wp + 1'b1;
            end
            // Rewind only makes sense while no more than D words were written since clear
            if (rewind) begin
                st_nxt.rp = rewind_pop ? (AW+1)'(1) : '0;
            end else if (pop) begin
                st_nxt.rp = st_r.rp + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    bmf_mem #(.W(W), .D(D)) u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .we(push),
        .waddr(st_r.wp[AW-1:0]),
        .wdata(in_data),
        .re(pop || (rewind && rewind_pop)),
        .raddr(raddr),
        .rdata(out_data)
    );

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_full_ignored: assert property (!in_ready && !clr |=> st_r.wp == $past(st_r.wp))
        else $error("write taken while full");
    a_empty_ignored: assert property (!out_valid && !clr && !rewind |=> $stable(st_r.rp))
        else $error("read taken while empty");
endmodule : bmf_fifo
`default_nettype wire

// ===== verification/bmf_tick_model.sv
// Writer and reader clock edges as one-cycle ticks at unrelated rates
`timescale 1ns/10ps
`default_nettype none
module bmf_tick_model #(
    parameter int WP = 4,
    parameter int RP = 5
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic wr_tick,
    output logic rd_tick
);
    int wc;
    int rc;
    // Ticks at least four cycles apart, launched off the sampling edge
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wc = 0;
            rc = 0;
            wr_tick <= 1'h0;
            rd_tick <= 1'h0;
        end else begin
            wc = (wc + 1) % WP;
            rc = (rc + 1) % RP;
            wr_tick <= (wc == 0);
            rd_tick <= (rc == 0);
        end
    end
endmodule : bmf_tick_model
`default_nettype wire

// ===== verification/test_bus_matching_dual_clock_fifo.sv
// Self-checking bench for the bus-matching buffer
`timescale 1ns/10ps
`default_nettype none
module test_bus_matching_dual_clock_fifo
    import bmf_pkg::*;
;
    logic clk = 1'h0, rst_n = 1'h0, wr_tick, rd_tick, write_enable_n = 1'h1, read_enable_n = 1'h1;
    logic master_clear_n = 1'h1, partial_clear_n = 1'h1, serial_load_enable_n = 1'h1;
    logic offset_load_select_n = 1'h1, retransmit_request_n = 1'h1, fall_through_or_serial_in = 1'h0;
    logic default_offset_sel_lo = 1'h0, default_offset_sel_hi = 1'h0, almost_flag_timing_select = 1'h0;
    logic retransmit_latency_select = 1'h0, byte_order_select = 1'h0, parity_placement_select = 1'h1;
    logic input_width_select = 1'h0, output_width_select = 1'h0;
    logic [WORD_W-1:0] data_in_bus = 18'h0, data_out_bus;
    logic empty_or_output_valid_n, full_or_input_space_n, half_full_flag_n;
    logic almost_empty_flag_n, almost_full_flag_n, power_down;
    int n_mismatch = 0, comparisons = 0;
    logic [15:0] lf = 16'hb69a;
    logic [WORD_W-1:0] q[$], hist[$];
    bmf_tick_model #(.WP(4), .RP(5)) tick_u (.clk, .rst_n, .wr_tick, .rd_tick);
    bmf_top dut_u (.clk, .rst_n, .wr_tick, .rd_tick, .write_enable_n, .read_enable_n, .data_in_bus,
        .data_out_bus, .master_clear_n, .partial_clear_n, .fall_through_or_serial_in, .serial_load_enable_n,
        .offset_load_select_n, .default_offset_sel_lo, .default_offset_sel_hi, .almost_flag_timing_select,
        .retransmit_request_n, .retransmit_latency_select, .byte_order_select, .parity_placement_select,
        .input_width_select, .output_width_select, .empty_or_output_valid_n, .full_or_input_space_n,
        .half_full_flag_n, .almost_empty_flag_n, .almost_full_flag_n, .power_down);
    initial forever #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [WORD_W-1:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return {lf[1:0], lf};
    endfunction : rnd
    task automatic chk(input string nm, input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic test_done();
        if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // Holds the request until the matching tick is sampled, then drops every strobe
    task automatic tick(input bit rd);
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if ((rd ? rd_tick : wr_tick) === 1'h1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            test_done();
        end
        @(negedge clk);
        {write_enable_n, read_enable_n, offset_load_select_n, serial_load_enable_n, retransmit_request_n} = 5'h1f;
    endtask : tick
    task automatic wr(input logic [WORD_W-1:0] d, input logic ld_n);
        @(negedge clk);
        data_in_bus = d;
        write_enable_n = 1'h0;
        offset_load_select_n = ld_n;
        tick(0);
        if (ld_n && q.size() < DEPTH) q.push_back(d);
        if (ld_n && hist.size() < DEPTH) hist.push_back(d);
    endtask : wr
    task automatic rd(input logic ld_n, input logic rt_n);
        @(negedge clk);
        read_enable_n = !rt_n;
        offset_load_select_n = ld_n;
        retransmit_request_n = rt_n;
        tick(1);
        repeat (2) @(negedge clk);
    endtask : rd
    // Straps: fall-through, table bit 2, table bits 1:0, retransmit latency, byte order, read width
    task automatic clear(input bit master, input logic [6:0] s);
        @(negedge clk);
        if (master) begin
            {fall_through_or_serial_in, offset_load_select_n, default_offset_sel_hi, default_offset_sel_lo,
                retransmit_latency_select, byte_order_select, output_width_select} = s;
            master_clear_n = 1'h0;
        end else partial_clear_n = 1'h0;
        repeat (2) @(negedge clk);
        chk("power_busy", power_down, 18'h0);
        {master_clear_n, partial_clear_n, offset_load_select_n} = 3'h7;
        repeat (3) @(negedge clk);
        q = {};
        hist = {};
    endtask : clear
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'h1;
        clear(1, 7'h2c);
        rd(0, 1);
        chk("empty_offset", data_out_bus, 18'h6);
        rd(0, 1);
        chk("full_offset", data_out_bus, 18'h6);
        for (int i = 19; i >= 0; i--) begin
            @(negedge clk);
            fall_through_or_serial_in = 20'h0a407 >> i;
            {offset_load_select_n, serial_load_enable_n} = 2'h0;
            tick(0);
        end
        rd(0, 1);
        chk("serial_empty", data_out_bus, 18'h29);
        rd(0, 1);
        chk("serial_full", data_out_bus, 18'h7);
        wr(18'h3, 0);
        // Bit 8 set: interspersed parity must drop it from the offset
        wr(18'h10c, 0);
        rd(0, 1);
        chk("par_empty", data_out_bus, 18'h3);
        rd(0, 1);
        chk("par_full", data_out_bus, 18'h0c);
        // One write past full must be dropped without disturbing the stored words
        repeat (DEPTH + 1) wr(rnd(), 1);
        repeat (3) @(negedge clk);
        chk("flags_full", {full_or_input_space_n, half_full_flag_n, almost_full_flag_n}, 18'h0);
        chk("power_idle", power_down, 18'h1);
        while (q.size() > 0) begin
            rd(1, 1);
            chk("data", data_out_bus, q.pop_front());
        end
        rd(1, 1);
        chk("flags_empty", {empty_or_output_valid_n, almost_empty_flag_n}, 18'h0);
        clear(0, 7'h0);
        rd(0, 1);
        chk("kept_offset", data_out_bus, 18'h3);
        repeat (3) wr(rnd(), 1);
        rd(1, 1);
        rd(1, 0);
        for (int i = 0; i < 3; i++) begin
            rd(1, 1);
            chk("retransmit", data_out_bus, hist[i]);
        end
        for (int b = 0; b < 2; b++) begin
            clear(1, {5'h09, b[0], 1'h1});
            wr(rnd(), 1);
            rd(1, 1);
            chk("byte_first", data_out_bus, b ? hist[0][8:0] : hist[0][17:9]);
            rd(1, 1);
            chk("byte_second", data_out_bus, b ? hist[0][17:9] : hist[0][8:0]);
        end
        clear(1, 7'h48);
        wr(rnd(), 1);
        repeat (20) @(negedge clk);
        chk("fall_valid", {empty_or_output_valid_n, full_or_input_space_n}, 18'h0);
        wr(rnd(), 1);
        repeat (20) @(negedge clk);
        chk("fall_first", data_out_bus, hist[0]);
        rd(1, 1);
        chk("fall_next", data_out_bus, hist[1]);
        rd(1, 0);
        chk("zero_latency", data_out_bus, hist[0]);
        // Narrow writes packed into wide words, with synchronous almost flags
        input_width_select = 1'h1;
        almost_flag_timing_select = 1'h1;
        clear(1, 7'h08);
        repeat (2) wr(rnd(), 1);
        rd(1, 1);
        chk("byte_pack", data_out_bus, {hist[0][8:0], hist[1][8:0]});
        test_done();
    end
endmodule : test_bus_matching_dual_clock_fifo
`default_nettype wire
